/* src/dps_ctrl.sv */
/*
 Controller end: issues commands for the user, enforcing precharge waits
 and the self refresh entry/exit sequence. One command per accepted req.
*/
module dps_ctrl (
   input  wire logic                        clk,
   input  wire logic                        sys_rst,
   input  wire logic                        req_valid,
   output logic                             req_ready,
   input  dps_pkg::dps_cmd_t                req_cmd,
   input  wire logic [dps_pkg::BA_W-1:0]    req_ba,
   input  wire logic [dps_pkg::ADDR_W-1:0]  req_addr,
   input  wire logic                        sr_enter,
   input  wire logic                        sr_exit,
   output logic                             in_sr,
   dps_if.ctrl                              lnk
);
   typedef enum logic [2:0] {
      DPS_C_RUN  = 3'h0,
      DPS_C_SRE  = 3'h1,
      DPS_C_SR   = 3'h2,
      DPS_C_CKH  = 3'h3,
      DPS_C_XNOP = 3'h4
   } dps_cst_t;

   dps_cst_t                  st_r, st_nxt;
   logic [dps_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
   logic [dps_pkg::CNT_W-1:0] wait_r [dps_pkg::NUM_BANKS];
   logic [dps_pkg::CNT_W-1:0] wait_nxt [dps_pkg::NUM_BANKS];
   logic                      cke_r, cke_nxt;
   logic [2:0]                cmd_r, cmd_nxt;
   logic [dps_pkg::BA_W-1:0]  ba_r, ba_nxt;
   logic [dps_pkg::ADDR_W-1:0] addr_r, addr_nxt;
   logic                      issue;

   // Activate stalls while its bank still precharges
   assign req_ready = (st_r == DPS_C_RUN) && !sr_enter &&
                      !(req_cmd == dps_pkg::DPS_CMD_ACT && wait_r[req_ba] != '0); // R02
   assign issue = req_valid && req_ready;

   always_comb begin
      st_nxt   = st_r;
      cnt_nxt  = cnt_r;
      cke_nxt  = cke_r;
      cmd_nxt  = 3'(dps_pkg::DPS_CMD_NOP);
      ba_nxt   = ba_r;
      addr_nxt = addr_r;
      for (int b = 0; b < dps_pkg::NUM_BANKS; b++) begin
         wait_nxt[b] = (wait_r[b] != '0) ? wait_r[b] - 1'b1 : wait_r[b];
      end
      if (cnt_r != '0) begin
         cnt_nxt = cnt_r - 1'b1;
      end
      case (st_r)
         DPS_C_RUN: begin
            if (sr_enter) begin
               st_nxt  = DPS_C_SRE;
               cmd_nxt = 3'(dps_pkg::DPS_CMD_REF);
               cke_nxt = 1'b0; // R10
               cnt_nxt = dps_pkg::CNT_W'(dps_pkg::CLK_PRE_CYC);
            end else if (issue) begin
               cmd_nxt  = 3'(req_cmd); // R03 R04
               ba_nxt   = req_ba;
               addr_nxt = req_addr;
               if (req_cmd == dps_pkg::DPS_CMD_PRE) begin
                  if (req_addr[dps_pkg::A10_POS]) begin
                     for (int b = 0; b < dps_pkg::NUM_BANKS; b++) begin
                        wait_nxt[b] = dps_pkg::CNT_W'(dps_pkg::TRPA_CYC); // R08
                     end
                  end else begin
                     wait_nxt[req_ba] = dps_pkg::CNT_W'(dps_pkg::TRP_CYC); // R08
                  end
               end
            end
         end
         DPS_C_SRE: begin
            // Clock keeps running one period past entry
            if (cnt_r == '0) begin
               st_nxt = DPS_C_SR; // R12
            end
         end
         DPS_C_SR: begin
            if (sr_exit) begin
               st_nxt  = DPS_C_CKH;
               cke_nxt = 1'b1; // R14
               cnt_nxt = dps_pkg::CNT_W'(dps_pkg::CKE_REG_CYC - 1);
            end
         end
         DPS_C_CKH: begin
            if (cnt_r == '0) begin
               st_nxt  = DPS_C_XNOP; // R15
               cnt_nxt = dps_pkg::CNT_W'(dps_pkg::DLL_CYC - dps_pkg::CKE_REG_CYC - 1);
            end
         end
         DPS_C_XNOP: begin
            if (cnt_r == '0) begin
               st_nxt = DPS_C_RUN; // R16 R17 R11
            end
         end
         default: st_nxt = DPS_C_RUN;
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_r   <= DPS_C_RUN;
         cnt_r  <= '0;
         cke_r  <= 1'b1;
         cmd_r  <= 3'(dps_pkg::DPS_CMD_NOP);
         ba_r   <= '0;
         addr_r <= '0;
         for (int b = 0; b < dps_pkg::NUM_BANKS; b++) begin
            wait_r[b] <= '0;
         end
      end else begin
         st_r   <= st_nxt;
         cnt_r  <= cnt_nxt;
         cke_r  <= cke_nxt;
         cmd_r  <= cmd_nxt;
         ba_r   <= ba_nxt;
         addr_r <= addr_nxt;
         wait_r <= wait_nxt;
      end
   end

   // SR entry keeps its REF one cycle only, then NOP with CKE low
   assign lnk.cke   = cke_r;
   assign lnk.cs_n  = 1'b0;
   assign lnk.ras_n = cmd_r[2];
   assign lnk.cas_n = cmd_r[1];
   assign lnk.we_n  = cmd_r[0];
   assign lnk.ba    = ba_r;
   assign lnk.addr  = addr_r;
   assign in_sr     = (st_r != DPS_C_RUN);
endmodule : dps_ctrl

/* include/dps_pkg.sv */
/*
 Constants, command encodings and timing counts for the precharge and
 self refresh block, shared by the device end and the controller end.
 Assumes a single 125 MHz clock and synchronous inputs.
*/
// What this block does
// R01: PRECHARGE closes open row, one or all banks
// R02: Controller waits tRP before activating bank
// R03: Other-bank READ/WRITE allowed during auto precharge
// R04: Precharged bank idle; activate before access
// R05: Repeat precharge accepted; last one times period
// R06: A10 selects single or all-bank precharge
// R07: Bank address picks bank; ignored for all
// R08: Controller applies tRPA after all, tRP single
// R09: Self refresh keeps data without clock
// R10: Self refresh entry is REFRESH with CKE low
// R11: DLL off in self refresh; 200 cycles before READ
// R12: Clock stable one period after entry
// R13: Only CKE heeded during self refresh
// R14: Clock stable one period before CKE rises
// R15: CKE held high four registered edges
// R16: Only NOP/DESELECT during exit delay
// R17: Simple approach: 200 NOP cycles after exit
// R18: EMR A6,A2 select 75, 150, 50 ohm termination
// R19: EMR A6,A2 zero disables termination
package dps_pkg;
   localparam int NUM_BANKS   = 4;
   localparam int BA_W        = 2;
   localparam int ADDR_W      = 14;
   localparam int A10_POS     = 10;
   localparam int A6_POS      = 6;
   localparam int A2_POS      = 2;
   localparam int CLK_PS      = 8000;
   localparam int TRP_PS      = 15000;
   localparam int TRPA_PS     = 17500;
   localparam int TRP_CYC     = (TRP_PS + CLK_PS - 1) / CLK_PS;
   localparam int TRPA_CYC    = (TRPA_PS + CLK_PS - 1) / CLK_PS;
   localparam int DLL_CYC     = 200;
   localparam int CKE_REG_CYC = 4;
   localparam int CLK_PRE_CYC = 1;
   localparam int CNT_W       = 8;

   // {ras_n, cas_n, we_n}, cs_n low
   typedef enum logic [2:0] {
      DPS_CMD_MRS  = 3'h0,
      DPS_CMD_REF  = 3'h1,
      DPS_CMD_PRE  = 3'h2,
      DPS_CMD_ACT  = 3'h3,
      DPS_CMD_WR   = 3'h4,
      DPS_CMD_RD   = 3'h5,
      DPS_CMD_NOP  = 3'h7
   } dps_cmd_t;

   localparam logic [BA_W-1:0] EMR_BA = 2'h1;

   typedef enum logic [1:0] {
      DPS_ODT_OFF = 2'h0,
      DPS_ODT_75  = 2'h1,
      DPS_ODT_150 = 2'h2,
      DPS_ODT_50  = 2'h3
   } dps_odt_t;
endpackage : dps_pkg

/* include/dps_if.sv */
/*
 Command link between controller and device end.
 Assumes both ends share clk.
*/
interface dps_if;
   logic                          cke;
   logic                          cs_n;
   logic                          ras_n;
   logic                          cas_n;
   logic                          we_n;
   logic [dps_pkg::BA_W-1:0]      ba;
   logic [dps_pkg::ADDR_W-1:0]    addr;

   modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, ba, addr);
   modport dev  (input  cke, cs_n, ras_n, cas_n, we_n, ba, addr);
endinterface : dps_if

/* src/dps_bank_timer.sv */
/*
 One bank's open/idle state and precharge countdown.
 Assumes single-cycle activate and precharge strobes.
*/
module dps_bank_timer #(
   parameter int CNT_W = dps_pkg::CNT_W
) (
   input  wire logic             clk,
   input  wire logic             sys_rst,
   input  wire logic             act,
   input  wire logic             pre,
   input  wire logic [CNT_W-1:0] pre_cyc,
   output logic                  open,
   output logic                  busy
);
   logic             open_r, open_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;

   always_comb begin
      open_nxt = open_r;
      cnt_nxt  = cnt_r;
      if (cnt_r != '0) begin
         cnt_nxt = cnt_r - 1'b1;
      end
      if (pre) begin
         open_nxt = 1'b0; // R01
         cnt_nxt  = pre_cyc; // R05
      end else if (act && cnt_r == '0) begin
         open_nxt = 1'b1; // R04
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         open_r <= 1'b0;
         cnt_r  <= '0;
      end else begin
         open_r <= open_nxt;
         cnt_r  <= cnt_nxt;
      end
   end

   assign open = open_r;
   assign busy = (cnt_r != '0);
endmodule : dps_bank_timer

/* src/dps_device.sv */
/*
 Device end: decodes precharge, self refresh entry/exit and EMR writes.
 Assumes controller honours its own waits; violations are flagged.
*/
module dps_device #(
   parameter int NUM_BANKS = dps_pkg::NUM_BANKS
) (
   input  wire logic             clk,
   input  wire logic             sys_rst,
   dps_if.dev                    lnk,
   output logic [NUM_BANKS-1:0]  bank_open,
   output logic [NUM_BANKS-1:0]  bank_busy,
   output logic                  self_refresh,
   output logic                  dll_on,
   output dps_pkg::dps_odt_t     odt_sel,
   output logic                  rd_early_err,
   output logic                  act_busy_err
);
   typedef enum logic [1:0] {
      DPS_D_RUN  = 2'h0,
      DPS_D_SR   = 2'h1,
      DPS_D_EXIT = 2'h2
   } dps_dst_t;

   dps_dst_t                  st_r, st_nxt;
   logic [dps_pkg::CNT_W-1:0] dcnt_r, dcnt_nxt;
   dps_pkg::dps_odt_t         odt_r, odt_nxt;
   logic                      rderr_r, rderr_nxt;
   logic                      acterr_r, acterr_nxt;
   logic [NUM_BANKS-1:0]      act_v, pre_v;
   logic [dps_pkg::CNT_W-1:0] pre_cyc;
   dps_pkg::dps_cmd_t         cmd;
   logic                      live;

   assign cmd  = dps_pkg::dps_cmd_t'({lnk.ras_n, lnk.cas_n, lnk.we_n});
   assign live = (st_r != DPS_D_SR) && lnk.cke && !lnk.cs_n; // R13

   always_comb begin
      act_v   = '0;
      pre_v   = '0;
      pre_cyc = dps_pkg::CNT_W'(dps_pkg::TRP_CYC);
      if (live && cmd == dps_pkg::DPS_CMD_PRE) begin
         if (lnk.addr[dps_pkg::A10_POS]) begin
            pre_v   = '1; // R06 R07
            pre_cyc = dps_pkg::CNT_W'(dps_pkg::TRPA_CYC);
         end else begin
            pre_v[lnk.ba] = 1'b1; // R07
         end
      end
      if (live && cmd == dps_pkg::DPS_CMD_ACT) begin
         act_v[lnk.ba] = 1'b1;
      end
   end

   for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
      dps_bank_timer #(.CNT_W(dps_pkg::CNT_W)) u_bank (
         .clk     (clk),
         .sys_rst (sys_rst),
         .act     (act_v[b]),
         .pre     (pre_v[b]),
         .pre_cyc (pre_cyc),
         .open    (bank_open[b]),
         .busy    (bank_busy[b])
      );
   end

   always_comb begin
      st_nxt     = st_r;
      dcnt_nxt   = dcnt_r;
      odt_nxt    = odt_r;
      rderr_nxt  = 1'b0;
      acterr_nxt = 1'b0;
      if (dcnt_r != '0) begin
         dcnt_nxt = dcnt_r - 1'b1;
      end
      case (st_r)
         DPS_D_RUN: begin
            if (!lnk.cke && !lnk.cs_n && cmd == dps_pkg::DPS_CMD_REF) begin
               st_nxt = DPS_D_SR; // R10
            end
         end
         DPS_D_SR: begin
            // Array contents held; no clock edges needed here
            if (lnk.cke) begin
               st_nxt   = DPS_D_EXIT; // R09 R11
               dcnt_nxt = dps_pkg::CNT_W'(dps_pkg::DLL_CYC - 1);
            end
         end
         DPS_D_EXIT: begin
            if (dcnt_r == '0) begin
               st_nxt = DPS_D_RUN;
            end
         end
         default: st_nxt = DPS_D_RUN;
      endcase
      if (live && cmd == dps_pkg::DPS_CMD_RD) begin
         rderr_nxt = (st_r == DPS_D_EXIT) || !bank_open[lnk.ba]; // R11 R04
      end
      if (live && cmd == dps_pkg::DPS_CMD_ACT) begin
         acterr_nxt = bank_busy[lnk.ba];
      end
      if (live && cmd == dps_pkg::DPS_CMD_MRS && lnk.ba == dps_pkg::EMR_BA) begin
         odt_nxt = dps_pkg::dps_odt_t'({lnk.addr[dps_pkg::A6_POS],
                                        lnk.addr[dps_pkg::A2_POS]}); // R18 R19
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_r     <= DPS_D_RUN;
         dcnt_r   <= '0;
         odt_r    <= dps_pkg::DPS_ODT_OFF;
         rderr_r  <= 1'b0;
         acterr_r <= 1'b0;
      end else begin
         st_r     <= st_nxt;
         dcnt_r   <= dcnt_nxt;
         odt_r    <= odt_nxt;
         rderr_r  <= rderr_nxt;
         acterr_r <= acterr_nxt;
      end
   end

   assign self_refresh = (st_r == DPS_D_SR);
   assign dll_on       = (st_r == DPS_D_RUN); // R11
   assign odt_sel      = odt_r;
   assign rd_early_err = rderr_r;
   assign act_busy_err = acterr_r;
endmodule : dps_device

/* testbench/dps_assertions.sv */
/*
 Link checker for the precharge and self refresh command link.
 Assumes the bench instantiates it beside the dps_if carrying both ends.
*/
module dps_assertions (
   input wire logic                       clk,
   input wire logic                       sys_rst,
   input wire logic                       cke,
   input wire logic                       cs_n,
   input wire logic                       ras_n,
   input wire logic                       cas_n,
   input wire logic                       we_n,
   input wire logic [dps_pkg::BA_W-1:0]   ba,
   input wire logic [dps_pkg::ADDR_W-1:0] addr
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic [2:0] cmd;
   logic       cke_r, cke_nxt;
   logic [7:0] exit_r, exit_nxt;
   assign cmd = {ras_n, cas_n, we_n};
   // Counter, since a 200-long repetition would not unroll cheaply
   always_comb begin
      cke_nxt  = cke;
      exit_nxt = (exit_r != 8'h00) ? exit_r - 8'h01 : 8'h00;
      if (cke && !cke_r) begin
         exit_nxt = 8'hC7;
      end
   end
   always_ff @(posedge clk) begin
      cke_r  <= sys_rst ? 1'b1 : cke_nxt;
      exit_r <= sys_rst ? 8'h00 : exit_nxt;
   end
   a_fall_is_ref: assert property ($fell(cke) |-> !cs_n && cmd == 3'h1)
      else $error("cke fell without refresh");
   a_fall_held: assert property ($fell(cke) |=> !cke)
      else $error("cke not held low after entry");
   a_sr_nop_only: assert property (!cke && !$fell(cke) |-> cs_n || cmd == 3'h7)
      else $error("command during self refresh");
   a_rise_after_low: assert property ($rose(cke) |-> $past(cke, 2) == 1'b0)
      else $error("cke rose too soon");
   a_rise_held_four: assert property ($rose(cke) |-> cke [*4])
      else $error("cke not held for four edges");
   a_exit_nop_wait: assert property ((cke && !cke_r) || exit_r != 8'h00
      |-> cs_n || cmd == 3'h7)
      else $error("command inside exit wait");
   a_pre_all_gap: assert property (!cs_n && cmd == 3'h2 && addr[10]
      |=> (cs_n || cmd != 3'h3) [*2])
      else $error("activate inside all-bank wait");
   a_pre_bank_gap: assert property (!cs_n && cmd == 3'h2 && !addr[10]
      |=> !(!cs_n && cmd == 3'h3 && ba == $past(ba)))
      else $error("activate inside bank wait");
   c_entry: cover property ($fell(cke));
   c_exit: cover property ($rose(cke));
   c_pre_all: cover property (!cs_n && cmd == 3'h2 && addr[10]);
endmodule : dps_assertions

/* testbench/tb.sv */
/*
 Self-checking bench joining controller and device ends over dps_if.
 Assumes a 125 MHz clock; a bench model tracks banks and termination.
*/
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic              clk = 1'b0;
   logic              sys_rst = 1'b1;
   logic              req_valid = 1'b0;
   logic              sr_enter = 1'b0;
   logic              sr_exit = 1'b0;
   dps_pkg::dps_cmd_t req_cmd = dps_pkg::DPS_CMD_NOP;
   logic [1:0]        req_ba = 2'h0;
   logic [13:0]       req_addr = 14'h0000;
   logic              req_ready, in_sr, self_refresh, dll_on, rd_early_err, act_busy_err;
   logic [3:0]        bank_open, bank_busy, m_open;
   dps_pkg::dps_odt_t odt_sel;
   logic [1:0]        m_odt, b;
   logic [31:0]       rv;
   logic              hit;
   logic              act_hit = 1'b0;
   int                err_count = 0, checks_done = 0, cyc = 0, n;
   always #4 clk = ~clk;
   dps_if lnk ();
   dps_ctrl i_dps_ctrl (.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid),
      .req_ready(req_ready), .req_cmd(req_cmd), .req_ba(req_ba), .req_addr(req_addr),
      .sr_enter(sr_enter), .sr_exit(sr_exit), .in_sr(in_sr), .lnk(lnk.ctrl));
   dps_device i_dps_device (.clk(clk), .sys_rst(sys_rst), .lnk(lnk.dev),
      .bank_open(bank_open), .bank_busy(bank_busy), .self_refresh(self_refresh),
      .dll_on(dll_on), .odt_sel(odt_sel), .rd_early_err(rd_early_err),
      .act_busy_err(act_busy_err));
   dps_assertions i_dps_assertions (.clk(clk), .sys_rst(sys_rst), .cke(lnk.cke),
      .cs_n(lnk.cs_n), .ras_n(lnk.ras_n), .cas_n(lnk.cas_n), .we_n(lnk.we_n),
      .ba(lnk.ba), .addr(lnk.addr));
   task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         err_count++;
         $display("[ERR] %s exp %0h seen %0h", nm, e, s);
      end
   endtask : chk
   task end_of_test;
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : end_of_test
   task step(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : step
   function automatic logic [13:0] ra(input logic a10);
      logic [31:0] r;
      r = $urandom;
      r[10] = a10;
      return r[13:0];
   endfunction : ra
   // Holds the request until ready is settled high, then one edge takes it
   task issue(input dps_pkg::dps_cmd_t c, input logic [1:0] bb, input logic [13:0] a);
      int k;
      k = 0;
      req_cmd = c;
      req_ba = bb;
      req_addr = a;
      req_valid = 1'b1;
      #1;
      while (req_ready !== 1'b1 && k < 50) begin
         step(1);
         k++;
      end
      chk("req_wait", k < 50, 1'b1);
      step(1);
      req_valid = 1'b0;
      if (c == dps_pkg::DPS_CMD_ACT) m_open[bb] = 1'b1;
      if (c == dps_pkg::DPS_CMD_PRE) m_open = a[10] ? 4'h0 : m_open & ~(4'h1 << bb);
      if (c == dps_pkg::DPS_CMD_MRS && bb == dps_pkg::EMR_BA) m_odt = {a[6], a[2]};
      step(1);
      chk("bank_open", bank_open, m_open);
      chk("odt_sel", odt_sel, m_odt);
   endtask : issue
   task busy_cnt(input logic [3:0] m, input int e);
      n = 0;
      repeat (5) begin
         if ((bank_busy & m) === m) n++;
         step(1);
      end
      chk("busy_cycles", n, e);
   endtask : busy_cnt
   task rd_watch(input logic e);
      hit = 1'b0;
      repeat (4) begin
         hit = hit | rd_early_err;
         step(1);
      end
      chk("rd_early_err", hit, e);
   endtask : rd_watch
   always @(posedge clk) begin
      cyc++;
      // Error pulse lasts one cycle, so keep it sticky
      if (act_busy_err === 1'b1) begin
         act_hit <= 1'b1;
      end
      // Whole run is under 1000 cycles; this only cuts a hang
      if (cyc == 5000) begin
         err_count++;
         end_of_test;
      end
   end
   initial begin
      rv = $urandom(32'h5976015b);
      m_open = 4'h0;
      m_odt = 2'h0;
      step(10);
      sys_rst = 1'b0;
      chk("dll_on", dll_on, 1'b1);
      for (int i = 0; i < 4; i++) begin
         rv = ra(1'b0);
         rv[6] = i[1];
         rv[2] = i[0];
         issue(dps_pkg::DPS_CMD_MRS, dps_pkg::EMR_BA, rv[13:0]);
      end
      issue(dps_pkg::DPS_CMD_MRS, 2'h0, ra(1'b1));
      for (int i = 0; i < 4; i++) issue(dps_pkg::DPS_CMD_ACT, i[1:0], ra(1'b0));
      rv = $urandom;
      b = rv[1:0];
      issue(dps_pkg::DPS_CMD_PRE, b, ra(1'b0));
      busy_cnt(4'h1 << b, dps_pkg::TRP_CYC);
      issue(dps_pkg::DPS_CMD_PRE, b, ra(1'b0));
      // Second one lands while the first still counts
      issue(dps_pkg::DPS_CMD_PRE, b, ra(1'b0));
      busy_cnt(4'h1 << b, dps_pkg::TRP_CYC);
      issue(dps_pkg::DPS_CMD_RD, b, ra(1'b0));
      rd_watch(1'b1);
      issue(dps_pkg::DPS_CMD_PRE, rv[3:2], ra(1'b1));
      busy_cnt(4'hF, dps_pkg::TRPA_CYC);
      issue(dps_pkg::DPS_CMD_ACT, b, ra(1'b0));
      issue(dps_pkg::DPS_CMD_RD, b, ra(1'b0));
      rd_watch(1'b0);
      // Activate right behind a precharge must stall
      issue(dps_pkg::DPS_CMD_PRE, b, ra(1'b0));
      issue(dps_pkg::DPS_CMD_ACT, b, ra(1'b0));
      sr_enter = 1'b1;
      n = 0;
      while (in_sr !== 1'b1 && n < 20) begin
         step(1);
         n++;
      end
      sr_enter = 1'b0;
      chk("sr_entry_wait", n < 20, 1'b1);
      step(3);
      chk("self_refresh", self_refresh, 1'b1);
      chk("dll_off", dll_on, 1'b0);
      step(20);
      chk("sr_banks", bank_open, m_open);
      sr_exit = 1'b1;
      n = 0;
      while (self_refresh !== 1'b0 && n < 20) begin
         step(1);
         n++;
      end
      sr_exit = 1'b0;
      chk("sr_exit_wait", n < 20, 1'b1);
      n = 0;
      while (dll_on !== 1'b1 && n < 400) begin
         step(1);
         n++;
      end
      chk("dll_wait", n >= dps_pkg::DLL_CYC - 2 && n <= dps_pkg::DLL_CYC, 1'b1);
      n = 0;
      while (in_sr !== 1'b0 && n < 300) begin
         step(1);
         n++;
      end
      chk("exit_nop_wait", n < 300, 1'b1);
      issue(dps_pkg::DPS_CMD_RD, b, ra(1'b0));
      rd_watch(1'b0);
      chk("act_busy_err", act_hit, 1'b0);
      end_of_test;
   end
endmodule : tb
